// File: src/nmahe_pkg.sv
// ==========================================
// Constants and types for the flash-mode access and parity block
package nmahe_pkg;
	localparam int ADDR_W = 24; // CPU word address width
	localparam int EM_A_W = 21; // External address lines
	localparam int DATA_W = 16;
	localparam int NSPACE = 4; // Chip-select spaces two to five
	localparam int PAR_W = 12; // Parity pairs per result
	localparam int CNT_W = 9; // Datum position within a block
	localparam logic [ADDR_W-1:0] SPACE_BASE = 24'h400000; // Space two base
	localparam int SPACE_SHIFT = 21; // Each space spans 2M words
	localparam logic [1:0] BW_8BIT = 2'h0; // Bus width select, 8-bit bus
	localparam logic [NSPACE-1:0] FLASH_EN_RESET = 4'h1; // Space two only
	localparam logic [NSPACE-1:0] START_RESET = 4'h0;
	// Strobe timing, in ns, and derived cycle counts
	localparam int CLK_NS = 10;
	localparam int SETUP_NS = 20;
	localparam int STROBE_NS = 40;
	localparam int HOLD_NS = 20;
	localparam int CYC_W = 4;
	localparam logic [CYC_W-1:0] SETUP_CYC = CYC_W'((SETUP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CYC_W-1:0] STROBE_CYC = CYC_W'((STROBE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CYC_W-1:0] HOLD_CYC = CYC_W'((HOLD_NS + CLK_NS - 1) / CLK_NS);

	typedef enum {ACC_IDLE, ACC_SETUP, ACC_STROBE, ACC_HOLD} nmahe_state_t;

	// One single asynchronous access request
	typedef struct packed {
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} nmahe_req_t;

	// Accumulated parity of one space
	typedef struct packed {
		logic [PAR_W-1:0] odd;
		logic [PAR_W-1:0] even;
	} nmahe_par_t;
endpackage

// File: src/nmahe_core.sv
// ==========================================
// Overview of operation
// - Lowest byte-lane pin driven only when the bus width select is 8-bit.
// - Space two sits at word 400000h; word address bits 21:1 go straight to address lines.
// - No phase sequencing; every command, address or data phase is one access.
// - Chip select released at the end of every single access.
// - Select is never held through read busy; such parts need external select.
// - Addresses pass through unchanged; only linear incrementing transfers work.
// - Flash-mode space with parity start set accumulates parity over 512 bytes.
// - Result only valid for at most 512 bytes per calculation.
// - Reading a space's parity result clears its start bit.
// - Writing one to a start bit clears that space's result first.
// - 8-bit part: column parities from bit index, row from byte index.
// - 16-bit part: column parities from word bit index, row from word index.
// - After reset flash mode is on for space two, off for three to five.
// - Flash mode enabled separately per space by its own enable bit.
`timescale 1ns/1ps
module nmahe_core (
	input wire logic core_clk, // 100 MHz clock
	input wire logic reset_n, // Synchronous reset, active low
	input wire logic reqValid, // Access request
	input wire nmahe_pkg::nmahe_req_t req, // Access write flag, address, data
	output logic reqReady, // Idle and able to take a request
	output logic accDone, // One-cycle pulse, access finished
	output logic [nmahe_pkg::DATA_W-1:0] accRData, // Read data of last access
	input wire logic [1:0] busWidthSelect, // External bus width
	input wire logic ctrlWrite, // Control write strobe
	input wire logic [nmahe_pkg::NSPACE-1:0] ctrlFlashEn, // Per-space flash mode
	input wire logic [nmahe_pkg::NSPACE-1:0] ctrlParStart, // Per-space parity start
	output logic [nmahe_pkg::NSPACE-1:0] spaceFlashModeEnable, // Flash mode state
	output logic [nmahe_pkg::NSPACE-1:0] spaceParityStart, // Parity start state
	input wire logic parRead, // Parity result read strobe
	input wire logic [1:0] parReadSel, // Space to read
	output nmahe_pkg::nmahe_par_t parRData, // Result, registered
	output logic [nmahe_pkg::EM_A_W-1:0] extAddr, // External address lines
	output logic [1:0] byteLanePins, // Byte-lane address pins
	output logic byteLaneLowOe, // Drive enable of the low lane pin
	output logic [nmahe_pkg::NSPACE-1:0] chipSelect_n, // Chip selects two to five
	output logic writeEnable_n, // Write strobe
	output logic outputEnable_n, // Read strobe
	input wire logic [nmahe_pkg::DATA_W-1:0] extDataIn, // Data pins in
	output logic [nmahe_pkg::DATA_W-1:0] extDataOut, // Data pins out
	output logic extDataOe // Data pins driven
);
	// ==========================================
	// Helpers

	// Space index of a CPU word address; bit 2 says it hits a space
	function automatic logic [2:0] spaceOf(input logic [nmahe_pkg::ADDR_W-1:0] a);
		logic [nmahe_pkg::ADDR_W-1:0] off;
		off = a - nmahe_pkg::SPACE_BASE;
		spaceOf = {(a >= nmahe_pkg::SPACE_BASE) && (off[nmahe_pkg::ADDR_W-1:
			nmahe_pkg::SPACE_SHIFT+2] == '0), off[nmahe_pkg::SPACE_SHIFT+1 -: 2]};
	endfunction

	// Parity contribution of one datum: odd half XORs the bit addresses of set
	// bits, even half their complements; one form serves both bus widths
	function automatic nmahe_pkg::nmahe_par_t parOf(input logic [nmahe_pkg::DATA_W-1:0] d,
		input logic [nmahe_pkg::CNT_W-1:0] pos, input logic wide);
		nmahe_pkg::nmahe_par_t p;
		logic [nmahe_pkg::PAR_W-1:0] ba;
		p = '0;
		for (int j = 0; j < nmahe_pkg::DATA_W; j++) begin
			if (wide) begin
				ba = {pos[7:0], 4'(j)};
			end else begin
				ba = {pos, 3'(j)};
			end
			if (d[j] && (wide || j < 8)) begin
				p.odd = p.odd ^ ba;
				p.even = p.even ^ ~ba;
			end
		end
		return p;
	endfunction

	// ==========================================
	// Access sequencer
	nmahe_pkg::nmahe_state_t state_q;
	logic [nmahe_pkg::CYC_W-1:0] cyc_q;
	nmahe_pkg::nmahe_req_t cur_q;
	logic [2:0] space_q;
	logic wide;
	logic strobeEnd;

	assign wide = busWidthSelect != nmahe_pkg::BW_8BIT;
	assign reqReady = state_q == nmahe_pkg::ACC_IDLE;
	assign strobeEnd = (state_q == nmahe_pkg::ACC_STROBE) && (cyc_q == 4'h1);

	// One request is one setup-strobe-hold access; nothing chains phases
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			state_q <= nmahe_pkg::ACC_IDLE;
			cyc_q <= '0;
			cur_q <= '0;
			space_q <= '0;
		end else begin
			case (state_q)
				nmahe_pkg::ACC_IDLE: begin
					if (reqValid) begin
						cur_q <= req;
						space_q <= spaceOf(req.addr);
						cyc_q <= nmahe_pkg::SETUP_CYC;
						state_q <= nmahe_pkg::ACC_SETUP;
					end
				end
				nmahe_pkg::ACC_SETUP: begin
					cyc_q <= cyc_q - 4'h1;
					if (cyc_q == 4'h1) begin
						cyc_q <= nmahe_pkg::STROBE_CYC;
						state_q <= nmahe_pkg::ACC_STROBE;
					end
				end
				nmahe_pkg::ACC_STROBE: begin
					cyc_q <= cyc_q - 4'h1;
					if (cyc_q == 4'h1) begin
						cyc_q <= nmahe_pkg::HOLD_CYC;
						state_q <= nmahe_pkg::ACC_HOLD;
					end
				end
				nmahe_pkg::ACC_HOLD: begin
					cyc_q <= cyc_q - 4'h1;
					if (cyc_q == 4'h1) begin
						state_q <= nmahe_pkg::ACC_IDLE;
					end
				end
				default: begin
					state_q <= nmahe_pkg::ACC_IDLE;
				end
			endcase
		end
	end

	// Pin drive; select drops after each hold, never kept across accesses
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			chipSelect_n <= '1;
			writeEnable_n <= 1'b1;
			outputEnable_n <= 1'b1;
			extAddr <= '0;
			byteLanePins <= '0;
			byteLaneLowOe <= 1'b0;
			extDataOut <= '0;
			extDataOe <= 1'b0;
		end else begin
			chipSelect_n <= '1;
			writeEnable_n <= 1'b1;
			outputEnable_n <= 1'b1;
			extDataOe <= 1'b0;
			if (state_q != nmahe_pkg::ACC_IDLE && !(state_q == nmahe_pkg::ACC_HOLD
				&& cyc_q == 4'h1)) begin
				chipSelect_n[space_q[1:0]] <= ~space_q[2];
				extAddr <= cur_q.addr[nmahe_pkg::EM_A_W:1];
				byteLanePins[1] <= cur_q.addr[0];
				byteLanePins[0] <= 1'b0;
				byteLaneLowOe <= !wide;
				extDataOut <= cur_q.wdata;
				extDataOe <= cur_q.write;
				if (state_q == nmahe_pkg::ACC_STROBE && cyc_q != 4'h1) begin
					writeEnable_n <= ~cur_q.write;
					outputEnable_n <= cur_q.write;
				end
			end else begin
				byteLaneLowOe <= 1'b0;
			end
		end
	end

	// Read data is taken at the end of the strobe, when the part has settled
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			accRData <= '0;
			accDone <= 1'b0;
		end else begin
			accDone <= (state_q == nmahe_pkg::ACC_HOLD) && (cyc_q == 4'h1);
			if (strobeEnd && !cur_q.write) begin
				accRData <= extDataIn;
			end
		end
	end

	// ==========================================
	// Control bits
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			spaceFlashModeEnable <= nmahe_pkg::FLASH_EN_RESET;
			spaceParityStart <= nmahe_pkg::START_RESET;
		end else begin
			if (ctrlWrite) begin
				spaceFlashModeEnable <= ctrlFlashEn;
			end
			for (int s = 0; s < nmahe_pkg::NSPACE; s++) begin
				// A fresh start written in the same cycle as a result read wins
				if (ctrlWrite && ctrlParStart[s]) begin
					spaceParityStart[s] <= 1'b1;
				end else if (parRead && parReadSel == 2'(s)) begin
					spaceParityStart[s] <= 1'b0;
				end
			end
		end
	end

	// ==========================================
	// Parity accumulators, one per space
	nmahe_pkg::nmahe_par_t par_q [nmahe_pkg::NSPACE];
	logic [nmahe_pkg::CNT_W-1:0] pos_q [nmahe_pkg::NSPACE];

	// Beyond 512 bytes the position wraps, so the result is not meaningful
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			for (int s = 0; s < nmahe_pkg::NSPACE; s++) begin
				par_q[s] <= '0;
				pos_q[s] <= '0;
			end
		end else begin
			for (int s = 0; s < nmahe_pkg::NSPACE; s++) begin
				if (ctrlWrite && ctrlParStart[s]) begin
					par_q[s] <= '0;
					pos_q[s] <= '0;
				end else if (strobeEnd && space_q == {1'b1, 2'(s)}
					&& spaceFlashModeEnable[s] && spaceParityStart[s]) begin
					par_q[s] <= par_q[s] ^ parOf(cur_q.write ? cur_q.wdata : extDataIn,
						pos_q[s], wide);
					pos_q[s] <= pos_q[s] + 9'h001;
				end
			end
		end
	end

	// Result read port
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			parRData <= '0;
		end else if (parRead) begin
			parRData <= par_q[parReadSel];
		end
	end
endmodule // nmahe_core

// File: tb/nmahe_assertions.sv
`timescale 1ns/1ps
// ==========================================
// Port checks, bound onto the core
module nmahe_assertions (
	input wire logic core_clk, // Clock
	input wire logic reset_n, // Reset
	input wire logic reqValid, // Request
	input wire nmahe_pkg::nmahe_req_t req, // Request fields
	input wire logic reqReady, // Idle
	input wire logic accDone, // Done pulse
	input wire logic [1:0] busWidthSelect, // Width
	input wire logic byteLaneLowOe, // Low lane drive
	input wire logic ctrlWrite, // Control strobe
	input wire logic [3:0] ctrlFlashEn, // Enables in
	input wire logic [3:0] ctrlParStart, // Starts in
	input wire logic [3:0] spaceFlashModeEnable, // Enables
	input wire logic [3:0] spaceParityStart, // Starts
	input wire logic parRead, // Result read
	input wire logic [1:0] parReadSel, // Read space
	input wire logic [20:0] extAddr, // Address lines
	input wire logic [3:0] chipSelect_n // Selects
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	sequence s_take; reqValid && reqReady; endsequence
	sequence s_wait; !accDone [*8] ##1 accDone; endsequence
	property p_done; s_take |=> s_wait; endproperty
	a_done: assert property (p_done) else $error("access length wrong");
	property p_pulse; accDone |=> !accDone; endproperty
	a_pulse: assert property (p_pulse) else $error("done longer than a cycle");
	property p_rel; accDone |-> &chipSelect_n; endproperty
	a_rel: assert property (p_rel) else $error("select held after access");
	property p_lane; byteLaneLowOe |-> busWidthSelect == nmahe_pkg::BW_8BIT; endproperty
	a_lane: assert property (p_lane) else $error("low lane pin on wide bus");
	// Pins are registered from the latched request, so they show two cycles after the take
	property p_addr; s_take |=> ##1 extAddr == $past(req.addr[21:1], 2); endproperty
	a_addr: assert property (p_addr) else $error("address lines wrong");
	property p_cs;
		s_take ##0 req.addr[23:21] == 3'h2 |=> ##1 chipSelect_n == 4'hE;
	endproperty
	a_cs: assert property (p_cs) else $error("space two select wrong");
	property p_clr; parRead && parReadSel == 2'h0 && !ctrlWrite |=> !spaceParityStart[0]; endproperty
	a_clr: assert property (p_clr) else $error("start kept after read");
	property p_en; ctrlWrite |=> spaceFlashModeEnable == $past(ctrlFlashEn); endproperty
	a_en: assert property (p_en) else $error("enable not loaded");
	property p_rst; $rose(reset_n) |-> spaceFlashModeEnable == 4'h1 && spaceParityStart == 4'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule // nmahe_assertions

// File: tb/nmahe_flash_model.sv
`timescale 1ns/1ps
// ==========================================
// Flash part on space two; command write rewinds the page pointer
module nmahe_flash_model (
	input wire logic core_clk, // Clock
	input wire logic select_n, // Chip enable
	input wire logic writeEnable_n, // Write strobe
	input wire logic outputEnable_n, // Read strobe
	input wire logic cmdLatch, // Command latch line
	input wire logic [15:0] dataIn, // From block
	output logic [15:0] dataOut // To block
);
	logic [15:0] page [0:511];
	logic [8:0] ptr_q = 9'h000;
	logic [15:0] last_q = 16'h0000;
	logic weSeen_q = 1'b1; // Idle level, so no false edge at start
	logic oeSeen_q = 1'b1;
	// Strobe ends spotted a cycle late, data is still held then
	always_ff @(posedge core_clk) begin
		weSeen_q <= writeEnable_n;
		oeSeen_q <= outputEnable_n;
		if (!select_n && writeEnable_n && !weSeen_q) begin
			if (cmdLatch)
				ptr_q <= 9'h000;
			else begin
				page[ptr_q] <= dataIn;
				ptr_q <= ptr_q + 9'h001;
			end
		end
		if (!select_n && outputEnable_n && !oeSeen_q) begin
			ptr_q <= ptr_q + 9'h001;
			last_q <= page[ptr_q];
		end
	end
	// Released bus shows inverse of last value, not a stale copy
	assign dataOut = (!select_n && !outputEnable_n) ? page[ptr_q] : ~last_q;
endmodule // nmahe_flash_model

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic reqValid = 1'b0;
	nmahe_pkg::nmahe_req_t req = '0;
	logic [1:0] busWidthSelect = 2'h0;
	logic ctrlWrite = 1'b0;
	logic [3:0] ctrlFlashEn = 4'h1;
	logic [3:0] ctrlParStart = 4'h0;
	logic parRead = 1'b0;
	logic [1:0] parReadSel = 2'h0;
	logic reqReady, accDone, byteLaneLowOe, writeEnable_n, outputEnable_n, extDataOe;
	logic [15:0] accRData, extDataIn, extDataOut;
	logic [3:0] spaceFlashModeEnable, spaceParityStart, chipSelect_n, csSeen;
	logic [4:0] mid;
	nmahe_pkg::nmahe_par_t parRData;
	logic [20:0] extAddr;
	logic [1:0] byteLanePins;
	int nFail = 0;
	int checked = 0;
	always #5 core_clk = ~core_clk;
	nmahe_core nmahe_core_i (.*);
	nmahe_flash_model nmahe_flash_model_i (.core_clk(core_clk), .select_n(chipSelect_n[0]),
		.writeEnable_n(writeEnable_n), .outputEnable_n(outputEnable_n),
		.cmdLatch(extAddr[12]), .dataIn(extDataOut), .dataOut(extDataIn));
	// ==========================================
	// Shared tasks
	task cmp(input string what, input logic [23:0] exp, input logic [23:0] got);
		checked++;
		if (got !== exp) begin
			nFail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task access(input logic wr, input logic [23:0] a, input logic [15:0] d);
		@(posedge core_clk) reqValid <= 1'b1;
		req <= '{wr, a, d};
		@(posedge core_clk) reqValid <= 1'b0;
		csSeen = 4'hF;
		mid = 5'h1F;
		for (int i = 0; i < 20 && accDone !== 1'b1; i++) begin
			@(negedge core_clk);
			csSeen &= chipSelect_n;
			// Mid-strobe snapshot of lanes, lane drive, data drive and active strobe
			if (i == 4) begin
				mid = {byteLanePins, byteLaneLowOe, extDataOe,
					wr ? writeEnable_n : outputEnable_n};
			end
		end
		cmp("done", 24'h1, 24'(accDone));
		cmp("byte lanes", 24'({a[0], 1'b0}), 24'(mid[4:3]));
		cmp("low lane drive", 24'(busWidthSelect == 2'h0), 24'(mid[2]));
		cmp("data drive and strobe", 24'({wr, 1'b0}), 24'(mid[1:0]));
		cmp("select", a[23:21] inside {[2:5]} ? 24'(~(4'h1 << (a[23:21] - 3'h2)) & 4'hF)
			: 24'hF, 24'(csSeen));
		cmp("select released", 24'hF, 24'(chipSelect_n));
	endtask
	task ctrl(input logic [3:0] en, input logic [3:0] st);
		@(posedge core_clk) ctrlWrite <= 1'b1;
		ctrlFlashEn <= en;
		ctrlParStart <= st;
		@(posedge core_clk) ctrlWrite <= 1'b0;
	endtask
	task read_par(input logic [1:0] s, input nmahe_pkg::nmahe_par_t e);
		@(posedge core_clk) parRead <= 1'b1;
		parReadSel <= s;
		@(posedge core_clk) parRead <= 1'b0;
		@(negedge core_clk) cmp("parity", e, parRData);
		cmp("start", 24'h0, 24'(spaceParityStart[s]));
	endtask
	// Odd half takes bits whose address bit k is one, even half the rest
	function automatic nmahe_pkg::nmahe_par_t par(input logic [15:0] d[4], input logic wide);
		logic [11:0] a;
		par = '0;
		for (int p = 0; p < 4; p++)
			for (int b = 0; b < (wide ? 16 : 8); b++)
				if (d[p][b]) begin
					a = wide ? {p[7:0], b[3:0]} : {p[8:0], b[2:0]};
					par.odd ^= a;
					par.even ^= ~a;
				end
	endfunction
	// ==========================================
	// Scenarios
	task map_test();
		logic [23:0] adr[6] = '{24'h400000, 24'h402000, 24'h401000, 24'h600000, 24'hA00000,
			24'h000100};
		cmp("enables", 24'h1, 24'(spaceFlashModeEnable));
		cmp("starts", 24'h0, 24'(spaceParityStart));
		for (int i = 0; i < 6; i++)
			access(1'b0, adr[i], 16'h0000);
		$display("test map done");
	endtask
	// Write then read back a block; restart must clear the old result
	task parity_test(input logic wide, input logic [15:0] d[4]);
		@(posedge core_clk) busWidthSelect <= wide ? 2'h1 : 2'h0;
		for (int r = 0; r < 2; r++) begin
			access(1'b1, 24'h402000, 16'h0080);
			ctrl(4'h1, 4'h1);
			for (int i = 0; i < 4; i++) begin
				access(r == 0, 24'h400000 + 24'(i), d[i]);
				if (r == 1)
					cmp("read data", 24'(d[i]), 24'(wide ? accRData : accRData & 16'h00FF));
			end
			read_par(2'h0, par(d, wide));
		end
		$display("test parity done");
	endtask
	task disabled_test();
		ctrl(4'h1, 4'h3);
		access(1'b1, 24'h600000, 16'h00FF);
		read_par(2'h1, '0);
		$display("test disabled space done");
	endtask
	task end_of_test();
		$display("comparisons %0d mismatches %0d", checked, nFail);
		if (nFail == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		@(negedge core_clk) map_test();
		parity_test(1'b0, '{16'h00A5, 16'h003C, 16'h0001, 16'h00FF});
		parity_test(1'b1, '{16'hA55A, 16'h0F01, 16'h8000, 16'hFFFF});
		disabled_test();
		end_of_test();
	end
	// Watchdog well past the 27 accesses needed
	initial begin
		#100us;
		nFail++;
		end_of_test();
	end
endmodule // tb_top
bind nmahe_core nmahe_assertions nmahe_assertions_i (.*);
